//--- cprp_pkg.sv
package cprp_pkg;

	localparam int unsigned CLK_HZ       = 20_000_000;
	localparam int unsigned IDLE_TIME_NS = 1000;
	localparam int unsigned IDLE_CYCLES  = (IDLE_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int unsigned SIG_BITS     = 16;
	localparam logic        SLEW_RESET   = 1'b0;
	localparam logic        ERASED_FUSE  = 1'b0;

	typedef enum logic [1:0] {
		CPRP_RUN,
		CPRP_STANDBY,
		CPRP_SLEEP,
		CPRP_LOCKED
	} cprp_mode_e;

	function automatic logic cprp_sleep_req(input logic en, input logic p1, input logic p2);
		return en & (p1 | p2);
	endfunction

endpackage

//--- cprp_pin_hold.sv
`timescale 1ns/1ns
// ----------------------------------------
// one output pin with freeze, keeper, lock
// ----------------------------------------
module cprp_pin_hold
(
	input  wire logic mclk_i,
	input  wire logic rst_i,
	input  wire logic hold_i,
	input  wire logic lock_i,
	input  wire logic prog_i,
	input  wire logic keeper_i,
	input  wire logic polarity_i,
	input  wire logic data_i,
	input  wire logic drive_i,
	output logic      pin_o,
	output logic      pin_oe_n_o
);

	logic val_q;
	logic oe_n_q;
	logic val_d;
	logic oe_n_d;
	logic freeze;

	assign freeze = hold_i | (prog_i & keeper_i);
	assign val_d  = freeze ? val_q : (data_i ^ polarity_i);
	// during programming only keeper pins drive (holding their value), whatever drive_i was; the rest float
	assign oe_n_d = lock_i ? 1'b1 : prog_i ? ~keeper_i : freeze ? oe_n_q : ~drive_i;

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			val_q  <= 1'b0;
			oe_n_q <= 1'b1;
		end
		else
		begin
			val_q  <= val_d;
			oe_n_q <= oe_n_d;
		end
	end

	assign pin_o      = val_q;
	assign pin_oe_n_o = oe_n_q;

endmodule

//--- cprp_top.sv
`timescale 1ns/1ns
module cprp_top
#(
	parameter int unsigned NUM_IO    = 8,
	parameter int unsigned NUM_MC    = 8,
	parameter bit          LOW_POWER = 1'b1
)
(
	input  wire logic                        mclk_i,
	input  wire logic                        rst_i,
	input  wire logic                        sleep_en_i,
	input  wire logic                        sleep_pin_first_i,
	input  wire logic                        sleep_pin_second_i,
	input  wire logic [NUM_IO-1:0]           io_in_i,
	input  wire logic [NUM_IO-1:0]           core_data_i,
	input  wire logic [NUM_IO-1:0]           core_drive_i,
	input  wire logic [NUM_IO-1:0]           polarity_i,
	input  wire logic [NUM_IO-1:0]           keeper_i,
	input  wire logic [NUM_IO-1:0]           fast_slew_cfg_i,
	input  wire logic [NUM_MC-1:0]           mc_used_i,
	input  wire logic [NUM_MC-1:0]           mc_low_power_cfg_i,
	input  wire logic                        isp_enable_i,
	input  wire logic                        prog_start_i,
	input  wire logic                        prog_done_i,
	input  wire logic                        prog_abort_i,
	input  wire logic                        fuse_program_i,
	input  wire logic                        read_pattern_i,
	input  wire logic                        read_signature_i,
	input  wire logic [cprp_pkg::SIG_BITS-1:0] signature_i,
	input  wire logic                        pattern_bit_i,
	input  wire logic [3:0]                  tap_pins_i,
	output logic [NUM_IO-1:0]                io_in_held_o,
	output logic [NUM_IO-1:0]                pin_o,
	output logic [NUM_IO-1:0]                pin_oe_n_o,
	output logic [NUM_IO-1:0]                fast_slew_o,
	output logic [NUM_MC-1:0]                mc_reduced_o,
	output logic                             asleep_o,
	output logic                             standby_o,
	output logic                             locked_o,
	output logic                             programming_o,
	output logic                             erased_o,
	output logic                             fuse_o,
	output logic                             read_valid_o,
	output logic [cprp_pkg::SIG_BITS-1:0]    read_data_o,
	output logic                             tap_active_o,
	output logic [3:0]                       tap_user_o
);

	// ----------------------------------------
	// sleep request and mode
	// ----------------------------------------
	localparam int unsigned IDLE_W = $clog2(cprp_pkg::IDLE_CYCLES + 1);

	cprp_pkg::cprp_mode_e mode_q;
	cprp_pkg::cprp_mode_e mode_d;
	logic [IDLE_W-1:0]    idle_q;
	logic [IDLE_W-1:0]    idle_d;
	logic [NUM_IO-1:0]    in_prev_q;
	logic                 sleep_req;
	logic                 hold;
	logic                 activity;
	logic                 prog_q;
	logic                 lock_q;
	logic                 erased_q;
	logic                 fuse_q;
	logic                 rd_v_q;
	logic [cprp_pkg::SIG_BITS-1:0] rd_q;
	logic [NUM_IO-1:0]    held_q;
	logic [NUM_IO-1:0]    slew_q;
	logic [NUM_MC-1:0]    red_q;
	logic [3:0]           tap_user_q;
	logic                 tap_act_q;
	logic                 asleep_q;
	logic                 standby_q;

	// sleep pins feed only the request, never the array
	assign sleep_req = cprp_pkg::cprp_sleep_req(sleep_en_i, sleep_pin_first_i, sleep_pin_second_i);
	assign hold      = sleep_req;
	// an output about to change counts as activity
	assign activity  = (io_in_i != in_prev_q) | ((core_data_i ^ polarity_i) != pin_o);
	assign idle_d    = activity ? '0 : (idle_q == IDLE_W'(cprp_pkg::IDLE_CYCLES)) ? idle_q : idle_q + 1'b1;

	always_comb
	begin
		mode_d = mode_q;
		unique case (mode_q)
			cprp_pkg::CPRP_RUN:
			begin
				if (lock_q)
					mode_d = cprp_pkg::CPRP_LOCKED;
				else if (sleep_req)
					mode_d = cprp_pkg::CPRP_SLEEP;
				else if (LOW_POWER && idle_q == IDLE_W'(cprp_pkg::IDLE_CYCLES))
					mode_d = cprp_pkg::CPRP_STANDBY;
			end
			cprp_pkg::CPRP_STANDBY:
			begin
				if (lock_q)
					mode_d = cprp_pkg::CPRP_LOCKED;
				else if (sleep_req)
					mode_d = cprp_pkg::CPRP_SLEEP;
				else if (activity)
					mode_d = cprp_pkg::CPRP_RUN;
			end
			cprp_pkg::CPRP_SLEEP:
			begin
				if (!sleep_req)
					mode_d = cprp_pkg::CPRP_RUN;
			end
			cprp_pkg::CPRP_LOCKED:
			begin
				if (!lock_q)
					mode_d = cprp_pkg::CPRP_RUN;
			end
		endcase
	end

	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			mode_q    <= cprp_pkg::CPRP_RUN;
			idle_q    <= '0;
			in_prev_q <= '0;
			asleep_q  <= 1'b0;
			standby_q <= 1'b0;
		end
		else
		begin
			mode_q    <= mode_d;
			asleep_q  <= (mode_d == cprp_pkg::CPRP_SLEEP);
			standby_q <= (mode_d == cprp_pkg::CPRP_STANDBY);
			idle_q    <= hold ? idle_q : idle_d;
			in_prev_q <= hold ? in_prev_q : io_in_i;
		end
	end

	// ----------------------------------------
	// input hold latches and configuration
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			held_q <= '0;
			slew_q <= {NUM_IO{cprp_pkg::SLEW_RESET}};
			red_q  <= '0;
		end
		else
		begin
			held_q <= hold ? held_q : io_in_i;
			slew_q <= hold ? slew_q : fast_slew_cfg_i;
			red_q  <= hold ? red_q : (mc_low_power_cfg_i | ~mc_used_i);
		end
	end

	// ----------------------------------------
	// programming, lock and security
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			prog_q     <= 1'b0;
			lock_q     <= 1'b0;
			erased_q   <= 1'b1;
			fuse_q     <= cprp_pkg::ERASED_FUSE;
			rd_v_q     <= 1'b0;
			rd_q       <= '0;
			tap_act_q  <= 1'b0;
			tap_user_q <= '0;
		end
		else
		begin
			tap_act_q  <= isp_enable_i;
			tap_user_q <= isp_enable_i ? 4'h0 : tap_pins_i;
			if (isp_enable_i && prog_start_i)
			begin
				prog_q   <= 1'b1;
				lock_q   <= 1'b0;
				erased_q <= 1'b1;
				fuse_q   <= cprp_pkg::ERASED_FUSE;
			end
			else if (prog_q && (prog_abort_i || !isp_enable_i))
			begin
				prog_q <= 1'b0;
				lock_q <= 1'b1;
			end
			else if (prog_q && prog_done_i)
			begin
				prog_q   <= 1'b0;
				erased_q <= 1'b0;
			end
			if (prog_q && fuse_program_i)
				fuse_q <= 1'b1;
			rd_v_q <= read_signature_i | (read_pattern_i & ~fuse_q);
			if (read_signature_i)
				rd_q <= signature_i;
			else if (read_pattern_i && !fuse_q)
				rd_q <= {{(cprp_pkg::SIG_BITS-1){1'b0}}, pattern_bit_i};
			else
				rd_q <= '0;
		end
	end

	// ----------------------------------------
	// output pins
	// ----------------------------------------
	for (genvar i = 0; i < NUM_IO; i++)
	begin : g_pin
		cprp_pin_hold u_pin
		(
			.mclk_i     (mclk_i),
			.rst_i      (rst_i),
			.hold_i     (hold),
			.lock_i     (lock_q),
			.prog_i     (prog_q),
			.keeper_i   (keeper_i[i]),
			.polarity_i (polarity_i[i]),
			.data_i     (core_data_i[i]),
			.drive_i    (core_drive_i[i]),
			.pin_o      (pin_o[i]),
			.pin_oe_n_o (pin_oe_n_o[i])
		);
	end

	assign io_in_held_o  = held_q;
	assign fast_slew_o   = slew_q;
	assign mc_reduced_o  = red_q;
	assign asleep_o      = asleep_q;
	assign standby_o     = standby_q;
	assign locked_o      = lock_q;
	assign programming_o = prog_q;
	assign erased_o      = erased_q;
	assign fuse_o        = fuse_q;
	assign read_valid_o  = rd_v_q;
	assign read_data_o   = rd_q;
	assign tap_active_o  = tap_act_q;
	assign tap_user_o    = tap_user_q;

endmodule

//--- cprp_board.sv
`timescale 1ns/1ns
module cprp_board
(
	input  wire logic	mclk_i,
	input  wire logic	rst_i,
	output logic [1:0]	sleep_o,
	output logic [3:0]	prog_o
);
	initial
	begin
		sleep_o = '0;
		prog_o = '0;
	end
	task automatic pins(input logic [1:0] v);
		wait (!rst_i);
		@(posedge mclk_i);
		#5 sleep_o = v;
	endtask
	task automatic pulse(input int b);
		@(posedge mclk_i);
		#5 prog_o[b] = 1'b1;
		@(posedge mclk_i);
		#5 prog_o = '0;
	endtask
endmodule

//--- cprp_top_properties.sv
`timescale 1ns/1ns
module cprp_top_properties
#(
	parameter int unsigned NUM_IO = 8
)
(
	input wire logic	mclk_i,
	input wire logic	rst_i,
	input wire logic	sleep_en_i,
	input wire logic	sleep_pin_first_i,
	input wire logic	sleep_pin_second_i,
	input wire logic [NUM_IO-1:0]	fast_slew_cfg_i,
	input wire logic	prog_abort_i,
	input wire logic	read_pattern_i,
	input wire logic [NUM_IO-1:0]	pin_o,
	input wire logic [NUM_IO-1:0]	pin_oe_n_o,
	input wire logic [NUM_IO-1:0]	fast_slew_o,
	input wire logic	asleep_o,
	input wire logic	locked_o,
	input wire logic	programming_o,
	input wire logic	fuse_o,
	input wire logic	read_valid_o
);
	wire slp = sleep_en_i & (sleep_pin_first_i | sleep_pin_second_i);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	AST_SLEEP_IN: assert property (slp && !programming_o && !locked_o |=> asleep_o)
		else $error("sleep not entered");
	AST_SLEEP_OUT: assert property (!slp |=> !asleep_o)
		else $error("sleep not left");
	AST_PIN_FROZEN: assert property (asleep_o && slp |=> $stable(pin_o))
		else $error("pin moved asleep");
	AST_OE_FROZEN: assert property (asleep_o && slp |=> $stable(pin_oe_n_o))
		else $error("enable moved asleep");
	AST_SLEW_FROZEN: assert property (asleep_o && slp |=> $stable(fast_slew_o))
		else $error("slew moved asleep");
	AST_SLEW: assert property (!slp |=> fast_slew_o == $past(fast_slew_cfg_i))
		else $error("slew wrong");
	AST_FUSE: assert property (read_pattern_i && fuse_o |=> !read_valid_o)
		else $error("pattern read allowed");
	AST_LOCK: assert property (programming_o && prog_abort_i && !slp |=> locked_o ##1 (&pin_oe_n_o))
		else $error("no lock");
endmodule
bind cprp_top cprp_top_properties #(.NUM_IO(NUM_IO)) u_props(.mclk_i(mclk_i),.rst_i(rst_i),
	.sleep_en_i(sleep_en_i),.sleep_pin_first_i(sleep_pin_first_i),.sleep_pin_second_i(sleep_pin_second_i),
	.fast_slew_cfg_i(fast_slew_cfg_i),.prog_abort_i(prog_abort_i),.read_pattern_i(read_pattern_i),
	.pin_o(pin_o),.pin_oe_n_o(pin_oe_n_o),.fast_slew_o(fast_slew_o),.asleep_o(asleep_o),.locked_o(locked_o),
	.programming_o(programming_o),.fuse_o(fuse_o),.read_valid_o(read_valid_o));

//--- tb_cprp_top.sv
`timescale 1ns/1ns
`define CHK(a,e) begin num_checks++; if ((a)!==(e)) begin n_errors++; $display("MISMATCH %0t %h %h",$time,a,e); end end
module tb_cprp_top;
	logic mclk_i='0,rst_i='1,en='0,isp='0,rp='0,rs='0,pb='0;
	logic [7:0] io='0,dat='0,drv='0,pol='0,kp='0,fst='0,usd='0,lp='0;
	logic [15:0] sig='0;
	logic [3:0] tap='0,prg;
	logic [1:0] slp;
	logic [31:0] snap;
	wire [7:0] hld,pin,oen,slw,red;
	wire [15:0] rd;
	wire [3:0] tu;
	wire asl,sby,lck,pgm,ers,fus,rv,ta;
	int n_errors=0,num_checks=0,seed=69,i,k;
	cprp_top DUT(.mclk_i(mclk_i),.rst_i(rst_i),.sleep_en_i(en),.sleep_pin_first_i(slp[0]),.sleep_pin_second_i(slp[1]),
		.io_in_i(io),.core_data_i(dat),.core_drive_i(drv),.polarity_i(pol),.keeper_i(kp),.fast_slew_cfg_i(fst),
		.mc_used_i(usd),.mc_low_power_cfg_i(lp),.isp_enable_i(isp),.prog_start_i(prg[0]),.prog_done_i(prg[1]),
		.prog_abort_i(prg[2]),.fuse_program_i(prg[3]),.read_pattern_i(rp),.read_signature_i(rs),.signature_i(sig),
		.pattern_bit_i(pb),.tap_pins_i(tap),.io_in_held_o(hld),.pin_o(pin),.pin_oe_n_o(oen),.fast_slew_o(slw),
		.mc_reduced_o(red),.asleep_o(asl),.standby_o(sby),.locked_o(lck),.programming_o(pgm),.erased_o(ers),
		.fuse_o(fus),.read_valid_o(rv),.read_data_o(rd),.tap_active_o(ta),.tap_user_o(tu));
	cprp_board PM(.mclk_i(mclk_i),.rst_i(rst_i),.sleep_o(slp),.prog_o(prg));
	always #25 mclk_i = ~mclk_i;
	task automatic step(input int n=1);
		repeat (n) @(posedge mclk_i);
		#5;
	endtask
	task automatic rnd();
		{dat,drv,pol,io} = $random(seed);
		{fst,usd,lp} = 24'($random(seed));
	endtask
	task automatic run_chk();
		`CHK(oen,~drv)
		`CHK(pin&drv,(dat^pol)&drv)
		`CHK({hld,slw,red},{io,fst,lp|~usd})
	endtask
	task automatic end_of_test();
		$display("checks %0d errors %0d",num_checks,n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (5) @(posedge mclk_i);
		`CHK({oen,slw,ers,fus},{8'hFF,8'h00,2'b10})
		#5 rst_i = '0;
		for (k = 0; k < 20; k++)
		begin
			rnd();
			step();
			run_chk();
		end
		for (k = 0; k < 4; k++)
		begin
			en = k != 0;
			PM.pins(k == 0 ? 2'b11 : k[1:0]);
			step();
			`CHK(asl,en)
			snap = {pin,oen,hld,slw};
			rnd();
			step(3);
			if (en)
				`CHK({asl,pin,oen,hld,slw},{1'b1,snap})
			else
				run_chk();
			PM.pins(2'b00);
			step();
			`CHK(asl,1'b0)
		end
		for (i = 0; i < 40 && sby !== 1'b1; i++)
			step();
		`CHK(sby,1'b1)
		dat = ~dat;
		step(2);
		`CHK(sby,1'b0)
		isp = '1;
		pb = 1'($random(seed));
		sig = 16'($random(seed));
		rp = '1;
		step();
		rp = '0;
		`CHK({rv,rd[0]},{1'b1,pb})
		kp = 8'($random(seed));
		drv = 8'hFF;
		step();
		PM.pulse(0);
		step();
		`CHK({pgm,oen,pin&kp},{1'b1,~kp,(dat^pol)&kp})
		PM.pulse(3);
		PM.pulse(1);
		`CHK({pgm,fus,ers},3'b010)
		rp = '1;
		step();
		rp = '0;
		rs = '1;
		`CHK(rv,1'b0)
		step();
		rs = '0;
		`CHK({rv,rd},{1'b1,sig})
		PM.pulse(0);
		PM.pulse(2);
		`CHK(lck,1'b1)
		step();
		`CHK(oen,8'hFF)
		PM.pulse(0);
		PM.pulse(1);
		isp = '0;
		tap = 4'($random(seed));
		step(2);
		`CHK({ta,tu},{1'b0,tap})
		end_of_test();
	end
endmodule
